// ---- sim/seep_props.sv ----
// Concurrent checks on the serial EEPROM link and device status.
module seep_props #(
   parameter int REL_CYC = 10
) (
   // System
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Link
   input  wire logic       sel_n,
   input  wire logic       sck,
   input  wire logic       hold_n,
   input  wire logic       so_o,
   input  wire logic       so_oe,
   // Device side
   input  wire logic [7:0] status,
   input  wire logic       powered_down,
   input  wire logic       array_erased,
   input  wire logic       releasing
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] rel_cnt;

   // Counts how long the release delay has been running.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rel_cnt <= 16'h0000;
      else if (releasing)
         rel_cnt <= rel_cnt + 16'h0001;
      else
         rel_cnt <= 16'h0000;
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence sel_idle_s;
      sel_n [*4];
   endsequence
   sequence hold_idle_s;
      !hold_n [*4];
   endsequence
   sequence erase_done_s;
      $rose(array_erased);
   endsequence

   desel_release_a: assert property (sel_idle_s |-> !so_oe)
      else $error("serial output driven while deselected");
   hold_release_a: assert property (hold_idle_s |-> !so_oe)
      else $error("serial output driven while paused");
   erase_busy_a: assert property (erase_done_s |-> $past(status[0]))
      else $error("erase finished without busy flag");
   erase_clear_a: assert property (erase_done_s |-> ##[0:2] !status[0])
      else $error("busy flag stuck after erase");
   erase_prot_a: assert property (erase_done_s |-> status[3:2] == 2'b00)
      else $error("erase ran with a protect bit set");
   pd_entry_a: assert property ($rose(powered_down) |-> sel_n)
      else $error("power-down entered while selected");
   pd_quiet_a: assert property (powered_down |=> $stable(status))
      else $error("status changed during power-down");
   pd_release_a: assert property ($fell(powered_down) |-> ##[0:2] releasing)
      else $error("power-down left without release delay");
   rel_len_a: assert property ($fell(releasing) |->
      rel_cnt >= REL_CYC - 1 && rel_cnt <= REL_CYC + 1)
      else $error("release delay of wrong length");
   so_edge_a: assert property (so_oe && $past(so_oe) && $changed(so_o) |-> !sck)
      else $error("serial output changed while clock high");
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench for the serial EEPROM master and device pair.
`include "seep_regs.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // Arbitrary signature value for this bench.
   localparam logic [7:0] SIG = 8'hA5;

   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        wp_level;
   logic [7:0]  status;
   logic        powered_down;
   logic        array_erased;
   logic        releasing;
   logic [31:0] rd;
   int          fail_count;
   int          n_checks;

   seep_if lnk ();

   seep_host seep_host_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .lnk(lnk), .wp_level(wp_level));

   seep_device #(.ERASE_CYC(400), .REL_CYC(10), .WSR_CYC(20),
                 .SIGNATURE(SIG)) seep_device_i (
      .hclk(hclk), .hresetn(hresetn), .lnk(lnk), .status(status),
      .powered_down(powered_down), .array_erased(array_erased),
      .releasing(releasing));

   seep_props #(.REL_CYC(10)) seep_props_i (
      .hclk(hclk), .hresetn(hresetn), .sel_n(lnk.sel_n), .sck(lnk.sck),
      .hold_n(lnk.hold_n), .so_o(lnk.so_o), .so_oe(lnk.so_oe),
      .status(status), .powered_down(powered_down),
      .array_erased(array_erased), .releasing(releasing));

   task automatic print_verdict();
      if (fail_count == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One single AHB-Lite transfer; read data lands in rd.
   task automatic ahb(input logic wr, input logic [31:0] addr, wdat);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= addr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wdat;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // Waits until the master reports its frame finished.
   task automatic frame_wait();
      int i;
      i = 0;
      do
      begin
         ahb(1'b0, `SEEP_A_STAT, 32'h0000_0000);
         i++;
      end
      while (rd[0] !== 1'b0 && i < 2000);
      check("frame_busy", {31'h0, rd[0]}, 32'h0000_0000);
      repeat (4) @(posedge hclk);
   endtask

   // Sends one frame and waits until the master reports it finished.
   task automatic frame(input logic [7:0] op, len, dat);
      ahb(1'b1, `SEEP_A_CTRL, {dat, len, op, 8'h01});
      repeat (3) @(posedge hclk);
      frame_wait();
   endtask

   task automatic wait_dev();
      for (int i = 0; i < 500 && (status[0] !== 1'b0 || releasing !== 1'b0);
           i++)
         @(posedge hclk);
      check("dev_idle", {31'h0, status[0] | releasing}, 32'h0000_0000);
   endtask

   initial
   begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   initial
   begin
      #1000000;
      fail_count++;
      print_verdict();
   end

   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      wp_level = 1'b1;
      fail_count = 0;
      n_checks = 0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      check("status", status, 32'h0000_0000);
      check("so_oe", lnk.so_oe, 32'h0000_0000);
      frame(8'h00, 8'h08, 8'h00);
      frame(`SEEP_OP_CHIP_ERASE, 8'h08, 8'h00);
      check("erased", array_erased, 32'h0000_0000);
      frame(`SEEP_OP_WRITE_ENABLE, 8'h08, 8'h00);
      check("wel", status[1], 32'h0000_0001);
      frame(`SEEP_OP_CHIP_ERASE, 8'h07, 8'h00);
      check("erased", array_erased, 32'h0000_0000);
      frame(`SEEP_OP_WRITE_ENABLE, 8'h08, 8'h00);
      frame(`SEEP_OP_WRITE_STATUS, 8'h10, 8'h84);
      wait_dev();
      check("prot", status & 8'h8C, 32'h0000_0084);
      frame(`SEEP_OP_WRITE_ENABLE, 8'h08, 8'h00);
      frame(`SEEP_OP_CHIP_ERASE, 8'h08, 8'h00);
      wait_dev();
      check("erased", array_erased, 32'h0000_0000);
      wp_level <= 1'b0;
      frame(`SEEP_OP_WRITE_ENABLE, 8'h08, 8'h00);
      frame(`SEEP_OP_WRITE_STATUS, 8'h10, 8'h00);
      wait_dev();
      check("prot", status & 8'h8C, 32'h0000_0084);
      wp_level <= 1'b1;
      frame(`SEEP_OP_WRITE_ENABLE, 8'h08, 8'h00);
      frame(`SEEP_OP_WRITE_STATUS, 8'h10, 8'h00);
      wait_dev();
      check("prot", status & 8'h8C, 32'h0000_0000);
      frame(`SEEP_OP_WRITE_ENABLE, 8'h08, 8'h00);
      frame(`SEEP_OP_CHIP_ERASE, 8'h08, 8'h00);
      check("busy", status[0], 32'h0000_0001);
      frame(`SEEP_OP_SIGNATURE, 8'h20, 8'h00);
      ahb(1'b0, `SEEP_A_RDAT, 32'h0000_0000);
      check("sig", rd[7:0], 32'h0000_0000);
      wait_dev();
      check("erased", array_erased, 32'h0000_0001);
      check("busy", status[0], 32'h0000_0000);
      frame(`SEEP_OP_POWER_DOWN, 8'h07, 8'h00);
      check("pd", powered_down, 32'h0000_0000);
      frame(`SEEP_OP_WRITE_ENABLE, 8'h08, 8'h00);
      frame(`SEEP_OP_POWER_DOWN, 8'h08, 8'h00);
      check("pd", powered_down, 32'h0000_0001);
      frame(`SEEP_OP_WRITE_STATUS, 8'h10, 8'h84);
      wait_dev();
      check("prot", status & 8'h8C, 32'h0000_0000);
      check("pd", powered_down, 32'h0000_0001);
      frame(`SEEP_OP_SIGNATURE, 8'h08, 8'h00);
      wait_dev();
      check("pd", powered_down, 32'h0000_0000);
      frame(`SEEP_OP_POWER_DOWN, 8'h08, 8'h00);
      frame(`SEEP_OP_SIGNATURE, 8'h20, 8'h00);
      ahb(1'b0, `SEEP_A_RDAT, 32'h0000_0000);
      check("sig", rd[7:0], {24'h000000, SIG});
      check("pd", powered_down, 32'h0000_0000);
      frame(`SEEP_OP_SIGNATURE, 8'h28, 8'h00);
      ahb(1'b0, `SEEP_A_RDAT, 32'h0000_0000);
      check("sig", rd[7:0], {24'h000000, SIG});
      ahb(1'b1, `SEEP_A_CTRL, {8'h00, 8'h28, `SEEP_OP_SIGNATURE, 8'h01});
      repeat (260) @(posedge hclk);
      check("so_oe", lnk.so_oe, 32'h0000_0001);
      ahb(1'b1, `SEEP_A_CTRL, 32'h0000_0002);
      repeat (40) @(posedge hclk);
      check("so_oe", lnk.so_oe, 32'h0000_0000);
      ahb(1'b0, `SEEP_A_STAT, 32'h0000_0000);
      check("busy", {31'h0, rd[0]}, 32'h0000_0001);
      ahb(1'b1, `SEEP_A_CTRL, 32'h0000_0000);
      frame_wait();
      ahb(1'b0, `SEEP_A_RDAT, 32'h0000_0000);
      check("sig", rd[7:0], {24'h000000, SIG});
      print_verdict();
   end
endmodule

// ---- verilog/seep_device.sv ----
// Serial EEPROM device end: command decode, erase, power-down, signature.
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`include "seep_regs.svh"
// Operation
// RULE1: Chip erase sets whole array to FFh.
// RULE2: Master sends write enable before erase.
// RULE3: Erase runs only if select rises after bit eight.
// RULE4: Write-in-progress bit set during erase.
// RULE5: Erase ignored when a protect bit set.
// RULE6: Power-down ignores read and write commands.
// RULE7: Power-down entered only on select rise after bit eight.
// RULE8: In power-down only signature command acts.
// RULE9: Signature after instruction and sixteen dummy bits.
// RULE10: Signature refused while a write cycle runs.
// RULE11: Signature repeats until select rises.
// RULE12: Early select rise still releases power-down.
// RULE13: Running cycle completes after deselect.
// RULE14: Output released while deselected.
// RULE15: Select rise after valid write starts cycle.
// RULE16: Select must go low once after power-up.
// RULE17: Protect pin blocks status write when enabled.
// RULE18: Protect pin change mid-cycle has no effect.
// RULE19: Sample on rising, update after falling clock.
// RULE20: Hold pauses sequence, clock and input ignored.
// RULE21: Hold acts at clock low or next fall.
// RULE22: Hold low releases output immediately.
// RULE23: Write enable latch clear at power-up.
// RULE24: Erase end clears write-in-progress bit.
module seep_device #(
   parameter int ERASE_CYC = `SEEP_ERASE_CYC,
   parameter int REL_CYC   = `SEEP_REL_CYC,
   parameter int WSR_CYC   = `SEEP_WSR_CYC,
   parameter int ADDR_W    = 16,
   parameter logic [7:0] SIGNATURE = 8'h5A
) (
   // System
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Link
   seep_if.device          lnk,
   // User side
   output logic [7:0]      status,
   output logic            powered_down,
   output logic            array_erased,
   output logic            releasing
);
   // No array is modelled for the erase state: one flag marks all bytes FFh.
   logic [2:0] sel_s;
   logic [2:0] sck_s;
   logic [1:0] si_s;
   logic [2:0] hold_s;
   logic [1:0] wp_s;
   logic       primed;
   logic       paused;
   logic [7:0] shreg;
   logic [5:0] bits;
   logic [7:0] opcode;
   logic [7:0] sig_sh;
   logic       sig_out;
   logic       so_bit;
   logic [31:0] busy_cnt;
   logic [31:0] rel_cnt;
   logic       erasing;
   logic       wsr_run;
   logic [7:0] wsr_val;

   wire sel_now   = sel_s[1];
   wire sel_rise  = sel_s[1] & ~sel_s[2];
   wire sel_fall  = ~sel_s[1] & sel_s[2];
   wire sck_rise  = sck_s[1] & ~sck_s[2];
   wire sck_fall  = ~sck_s[1] & sck_s[2];
   wire hold_now  = hold_s[1];
   wire write_in_progress_flag       = status[`SEEP_SR_WIP];
   wire write_enable_latch       = status[`SEEP_SR_WEL];
   wire bp_any    = status[`SEEP_SR_BP_LO] | status[`SEEP_SR_BP_HI];
   wire active    = primed & ~sel_now & ~paused;
   wire take_bit  = active & sck_rise;
   wire [7:0] next_sh = {shreg[6:0], si_s[1]};
   wire ended8    = (bits == 6'd8);
   wire ended16   = (bits == 6'd16);
   wire is_sig    = (opcode == `SEEP_OP_SIGNATURE);
   wire sig_ready = (bits >= 6'(8 + ADDR_W));
   wire wsr_block = status[`SEEP_SR_PEN] & ~wp_s[1];
   wire cmd_ok    = ~powered_down & ~write_in_progress_flag;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sel_s  <= 3'h7;
         sck_s  <= 3'h0;
         si_s   <= 2'h0;
         hold_s <= 3'h7;
         wp_s   <= 2'h3;
      end
      else
      begin
         sel_s  <= {sel_s[1:0], lnk.sel_n};
         sck_s  <= {sck_s[1:0], lnk.sck};
         si_s   <= {si_s[0], lnk.si};
         hold_s <= {hold_s[1:0], lnk.hold_n};
         wp_s   <= {wp_s[0], lnk.wp_n};
      end
   end

   // Hold takes effect with clock low, else at the next falling edge.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         paused <= 1'b0;
      else if (sel_now)
         paused <= 1'b0;
      else if (~sck_s[1] | sck_fall)
         paused <= ~hold_now; // RULE20 RULE21
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         primed <= 1'b0;
      else if (sel_fall)
         primed <= 1'b1; // RULE16
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         shreg  <= 8'h00;
         bits   <= 6'h00;
         opcode <= 8'h00;
      end
      else if (sel_now)
      begin
         bits <= 6'h00;
      end
      else if (take_bit) // RULE19
      begin
         shreg <= next_sh;
         if (bits != 6'h3F)
            bits <= bits + 6'h01;
         if (bits == 6'd7)
            opcode <= next_sh;
      end
   end

   // Signature shifter: output changes only after falling clock edges.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sig_sh  <= 8'h00;
         sig_out <= 1'b0;
         so_bit  <= 1'b0;
      end
      else if (sel_now)
      begin
         sig_out <= 1'b0;
      end
      else if (active & sck_fall & is_sig & sig_ready & ~write_in_progress_flag) // RULE9 RULE10
      begin
         // A lone marker bit means one pass is done, so start over.
         if (!sig_out || sig_sh == 8'h80)
         begin
            so_bit  <= SIGNATURE[7];
            sig_sh  <= {SIGNATURE[6:0], 1'b1}; // RULE11
         end
         else
         begin
            so_bit <= sig_sh[7];
            sig_sh <= {sig_sh[6:0], 1'b0};
         end
         sig_out <= 1'b1; // RULE19
      end
   end

   // Busy and release counters; deselect never cuts a running cycle.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         status       <= `SEEP_SR_RESET; // RULE23
         busy_cnt     <= 32'h0;
         rel_cnt      <= 32'h0;
         erasing      <= 1'b0;
         wsr_run      <= 1'b0;
         wsr_val      <= 8'h00;
         powered_down <= 1'b0;
         array_erased <= 1'b0;
         releasing    <= 1'b0;
      end
      else
      begin
         if (write_in_progress_flag)
         begin
            if (busy_cnt != 32'h0)
               busy_cnt <= busy_cnt - 32'h1; // RULE13 RULE18
            else
            begin
               status[`SEEP_SR_WIP] <= 1'b0; // RULE24
               status[`SEEP_SR_WEL] <= 1'b0;
               if (erasing)
                  array_erased <= 1'b1; // RULE1
               if (wsr_run)
               begin
                  status[`SEEP_SR_PEN]   <= wsr_val[`SEEP_SR_PEN];
                  status[`SEEP_SR_BP_HI] <= wsr_val[`SEEP_SR_BP_HI];
                  status[`SEEP_SR_BP_LO] <= wsr_val[`SEEP_SR_BP_LO];
               end
               erasing <= 1'b0;
               wsr_run <= 1'b0;
            end
         end
         if (releasing)
         begin
            if (rel_cnt != 32'h0)
               rel_cnt <= rel_cnt - 32'h1;
            else
               releasing <= 1'b0;
         end
         if (sel_rise & primed & ~paused)
         begin
            if (powered_down)
            begin
               if (opcode == `SEEP_OP_SIGNATURE && bits >= 6'd8) // RULE8
               begin
                  powered_down <= 1'b0; // RULE12
                  releasing    <= 1'b1;
                  rel_cnt      <= 32'(REL_CYC);
               end
            end
            else if (cmd_ok & ended8) // RULE6 RULE3 RULE7 RULE15
            begin
               case (opcode)
                  `SEEP_OP_WRITE_ENABLE:
                     status[`SEEP_SR_WEL] <= 1'b1; // RULE2
                  `SEEP_OP_CHIP_ERASE:
                     if (write_enable_latch & ~bp_any) // RULE5
                     begin
                        status[`SEEP_SR_WIP] <= 1'b1; // RULE4
                        erasing      <= 1'b1;
                        array_erased <= 1'b0;
                        busy_cnt     <= 32'(ERASE_CYC);
                     end
                  `SEEP_OP_POWER_DOWN:
                     powered_down <= 1'b1;
                  default:
                     ;
               endcase
            end
            else if (cmd_ok & ended16 & opcode == `SEEP_OP_WRITE_STATUS)
            begin
               if (write_enable_latch & ~wsr_block) // RULE17
               begin
                  status[`SEEP_SR_WIP] <= 1'b1;
                  wsr_run  <= 1'b1;
                  wsr_val  <= shreg;
                  busy_cnt <= 32'(WSR_CYC);
               end
            end
         end
      end
   end

   // Hold low releases the output at once, whatever the clock.
   assign lnk.so_oe = ~sel_now & hold_now & sig_out; // RULE14 RULE22
   assign lnk.so_o  = so_bit;
endmodule

// ---- verilog/seep_host.sv ----
// Serial EEPROM master end: register-driven frame engine over AHB-Lite.
`include "seep_regs.svh"
module seep_host #(
   parameter int HALF = `SEEP_SCK_HALF
) (
   // AHB-Lite slave
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Link
   seep_if.host             lnk,
   // Protect strap
   input  wire logic        wp_level
);
   seep_pkg::seep_host_st_t st;
   logic        wr_pend;
   logic [31:0] wr_addr;
   logic [31:0] rd_addr;
   logic [7:0]  op;
   logic [7:0]  len;
   logic [7:0]  wd;
   logic        hold_req;
   logic [7:0]  cnt;
   logic [7:0]  tx;
   logic [7:0]  rx;
   logic [7:0]  div;
   logic [1:0]  so_s;

   wire addr_ok = hsel & htrans[1] & hready;
   wire wr_go   = wr_pend & (wr_addr == `SEEP_A_CTRL) & hwdata[`SEEP_CTRL_GO];
   wire busy    = (st != seep_pkg::SEEP_IDLE);
   wire tick    = (div == 8'(HALF - 1));
   wire may_rise = lnk.hold_n & ~hold_req;
   wire [31:0] stat_w = {24'h0, rx[6:0], busy};
   wire [31:0] ctrl_w = {wd, len, op, 6'h0, hold_req, 1'b0};
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = (rd_addr == `SEEP_A_CTRL) ? ctrl_w :
                      (rd_addr == `SEEP_A_STAT) ? stat_w :
                      (rd_addr == `SEEP_A_RDAT) ? {24'h0, rx} : 32'h0;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 32'h0;
         rd_addr <= 32'h0;
      end
      else
      begin
         wr_pend <= addr_ok & hwrite;
         if (addr_ok)
         begin
            wr_addr <= haddr;
            rd_addr <= haddr;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         so_s <= 2'h0;
      else
         so_s <= {so_s[0], lnk.so_o & lnk.so_oe};
   end

   // Sends len bits of op then wd; clock idles low, data changes on fall.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st       <= seep_pkg::SEEP_IDLE;
         op       <= 8'h00;
         len      <= 8'h00;
         wd       <= 8'h00;
         hold_req <= 1'b0;
         cnt      <= 8'h00;
         tx       <= 8'h00;
         rx       <= 8'h00;
         div      <= 8'h00;
         lnk.sel_n  <= 1'b1;
         lnk.sck    <= 1'b0;
         lnk.si     <= 1'b0;
         lnk.hold_n <= 1'b1;
         lnk.wp_n   <= 1'b1;
      end
      else
      begin
         lnk.wp_n <= wp_level;
         if (wr_pend && wr_addr == `SEEP_A_CTRL)
            hold_req <= hwdata[`SEEP_CTRL_HOLD];
         // Hold only moves while the clock is low.
         if (!lnk.sck)
            lnk.hold_n <= ~hold_req; // RULE21
         div <= tick ? 8'h00 : div + 8'h01;
         case (st)
            seep_pkg::SEEP_IDLE:
               if (wr_go)
               begin
                  op        <= hwdata[`SEEP_CTRL_OP_LSB +: 8];
                  len       <= hwdata[`SEEP_CTRL_LEN_LSB +: 8];
                  wd        <= hwdata[`SEEP_CTRL_WD_LSB +: 8];
                  tx        <= hwdata[`SEEP_CTRL_OP_LSB +: 8];
                  cnt       <= 8'h00;
                  lnk.sel_n <= 1'b0;
                  lnk.si    <= hwdata[`SEEP_CTRL_OP_LSB + 7];
                  div       <= 8'h00;
                  st        <= seep_pkg::SEEP_SHIFT;
               end
            seep_pkg::SEEP_SHIFT:
               if (tick && (lnk.sck || may_rise)) // RULE20 RULE21
               begin
                  if (!lnk.sck)
                  begin
                     lnk.sck <= 1'b1;
                     cnt     <= cnt + 8'h01;
                  end
                  else
                  begin
                     // Sampled late in the high phase, because the answer
                     // comes back through two pairs of synchronisers.
                     lnk.sck <= 1'b0;
                     rx      <= {rx[6:0], so_s[1]};
                     if (cnt == len)
                        st <= seep_pkg::SEEP_END;
                     else
                     begin
                        if (cnt == 8'd8)
                        begin
                           lnk.si <= wd[7];
                           tx     <= wd;
                        end
                        else
                        begin
                           lnk.si <= tx[6];
                           tx     <= {tx[6:0], 1'b0};
                        end
                     end
                  end
               end
            seep_pkg::SEEP_END:
               if (tick)
               begin
                  lnk.sel_n <= 1'b1;
                  st        <= seep_pkg::SEEP_IDLE;
               end
            default:
               st <= seep_pkg::SEEP_IDLE;
         endcase
      end
   end
endmodule

// ---- verilog/seep_if.sv ----
// Serial link between the EEPROM master and the EEPROM device.
interface seep_if;
   logic sel_n;
   logic sck;
   logic si;
   logic hold_n;
   logic wp_n;
   logic so_o;
   logic so_oe;
   modport device (input sel_n, sck, si, hold_n, wp_n, output so_o, so_oe);
   modport host (output sel_n, sck, si, hold_n, wp_n, input so_o, so_oe);
endinterface

// ---- verilog/seep_pkg.sv ----
// Types used by the serial EEPROM master end.
package seep_pkg;
   typedef enum logic [1:0] {SEEP_IDLE, SEEP_SHIFT, SEEP_END} seep_host_st_t;
endpackage

// ---- verilog/seep_regs.svh ----
// Instruction codes, status bit positions and timing counts for the serial EEPROM link.
`ifndef SEEP_REGS_SVH
`define SEEP_REGS_SVH
`define SEEP_OP_WRITE_ENABLE  8'h06
`define SEEP_OP_READ_STATUS   8'h05
`define SEEP_OP_WRITE_STATUS  8'h01
`define SEEP_OP_CHIP_ERASE    8'hC7
`define SEEP_OP_POWER_DOWN    8'hB9
`define SEEP_OP_SIGNATURE     8'hAB
`define SEEP_SR_WIP           0
`define SEEP_SR_WEL           1
`define SEEP_SR_BP_LO         2
`define SEEP_SR_BP_HI         3
`define SEEP_SR_PEN           7
`define SEEP_SR_RESET         8'h00
`define SEEP_ERASE_NS         10000000
`define SEEP_ERASE_CYC        ((`SEEP_ERASE_NS + 19) / 20)
`define SEEP_REL_NS           100000
`define SEEP_REL_CYC          ((`SEEP_REL_NS + 19) / 20)
`define SEEP_WSR_NS           5000000
`define SEEP_WSR_CYC          ((`SEEP_WSR_NS + 19) / 20)
`define SEEP_SCK_HALF         4
`define SEEP_A_CTRL           32'h0000_0000
`define SEEP_A_STAT           32'h0000_0004
`define SEEP_A_RDAT           32'h0000_0008
`define SEEP_CTRL_GO          0
`define SEEP_CTRL_HOLD        1
`define SEEP_CTRL_OP_LSB      8
`define SEEP_CTRL_LEN_LSB     16
`define SEEP_CTRL_WD_LSB      24
`endif
